// ==== design/tbx_pkg.sv ====
// package: register map, field layout and carrier types for the trigger crossbar
//
// Overview of operation
// RULE1: seven board-side pins and seven shared trigger-line pins form the crossbar.
// RULE2: pin a2 shared by counter2 output/counter1 gate; a4 by counter5 output/stop trigger.
// RULE3: pin2 drive bit set drives a2 from counter2 output, else not.
// RULE4: pin2 receive bit set feeds counter1 gate from a2, else not.
// RULE5: both pin2 bits set: counter1 gate follows counter2 output via pin.
// RULE6: pin4 drive bit set drives a4 from counter5 output, else not.
// RULE7: pin4 receive bit set feeds stop trigger from a4, else not.
// RULE8: both pin4 bits set: stop trigger follows counter5 output via pin.
// RULE9: any a pin may source from any b pin and vice versa.
// RULE10: each shift write shifts in bit 0 only of the written byte.
// RULE11: writing 0 to strobe loads the 56-bit pattern into active routing.
// RULE12: low 28 bits configure b pins, high 28 bits configure a pins.
// RULE13: each half is seven 4-bit fields: 3-bit source plus output enable.
// RULE14: source value selects the same-numbered pin on the opposite side.
// RULE15: source select in upper three field bits, output enable lowest.
// RULE16: enable set drives pin from source; clear leaves pin undriven.
// RULE17: software shifts pattern bit 0 first through bit 55, then strobes.
// RULE18: software clears enables of inputs and unused pins, sets outputs.
// RULE19: field for pin n occupies bits 4n+3 down to 4n of its half.
// RULE20: after reset every active output enable is cleared.
package tbx_pkg;
    localparam int unsigned PIN_COUNT = 7;
    localparam int unsigned FIELD_W = 4;
    localparam int unsigned HALF_W = PIN_COUNT * FIELD_W;
    localparam int unsigned PATTERN_W = 2 * HALF_W;
    localparam int unsigned SEL_LSB = 1;
    localparam int unsigned OE_BIT = 0;
    localparam int unsigned B_HALF_LSB = 0;
    localparam int unsigned A_HALF_LSB = HALF_W;

    // register byte offsets
    localparam logic [7:0] SHIFT_IN_OFS = 8'h00;
    localparam logic [7:0] LOAD_STROBE_OFS = 8'h04;
    localparam logic [7:0] SHARED_CTRL_OFS = 8'h08;
    localparam logic [7:0] PENDING_LO_OFS = 8'h0C;
    localparam logic [7:0] PENDING_HI_OFS = 8'h10;
    localparam logic [7:0] ACTIVE_LO_OFS = 8'h14;
    localparam logic [7:0] ACTIVE_HI_OFS = 8'h18;

    // shared control register bits
    localparam int unsigned PIN2_DRIVE_BIT = 0;
    localparam int unsigned PIN2_RECEIVE_BIT = 1;
    localparam int unsigned PIN4_DRIVE_BIT = 2;
    localparam int unsigned PIN4_RECEIVE_BIT = 3;

    localparam logic [55:0] PATTERN_RESET = 56'h0;
    localparam logic [3:0] SHARED_CTRL_RESET = 4'h0;
    localparam logic [7:0] STROBE_LOAD_VALUE = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [6:0] din;
        logic [6:0] dout;
        logic [6:0] oe;
    } tbx_pins_t;

    typedef struct packed {
        logic shared_pin4_receive_en;
        logic shared_pin4_drive_en;
        logic shared_pin2_receive_en;
        logic shared_pin2_drive_en;
    } tbx_shared_ctrl_t;
endpackage

// ==== design/tbx_switch_core.sv ====
// combinational crossbar: routes between board-side and trigger-line pins
`timescale 1ns/1ns
`default_nettype none
module tbx_switch_core #(
    parameter int unsigned PINS = 7
) (
    input wire logic [55:0] active_pattern,
    input wire logic [PINS-1:0] a_in,
    input wire logic [PINS-1:0] b_in,
    output logic [PINS-1:0] a_out,
    output logic [PINS-1:0] a_oe,
    output logic [PINS-1:0] b_out,
    output logic [PINS-1:0] b_oe
);
    function automatic logic [3:0] field_of(input logic [27:0] half, input int unsigned n);
        field_of = half[4*n +: 4]; // RULE19
    endfunction

    function automatic logic pick(input logic [PINS-1:0] src, input logic [3:0] fld);
        logic [2:0] sel;
        sel = fld[tbx_pkg::SEL_LSB +: 3]; // RULE15
        pick = (int'(sel) < PINS) ? src[sel] : 1'b0; // RULE14
    endfunction

    logic [27:0] b_half;
    logic [27:0] a_half;

    always_comb
    begin
        b_half = active_pattern[tbx_pkg::B_HALF_LSB +: tbx_pkg::HALF_W]; // RULE12
        a_half = active_pattern[tbx_pkg::A_HALF_LSB +: tbx_pkg::HALF_W]; // RULE12
        for (int unsigned n = 0; n < PINS; n++)
        begin
            // RULE9 RULE13
            a_out[n] = pick(b_in, field_of(a_half, n));
            a_oe[n] = field_of(a_half, n)[tbx_pkg::OE_BIT]; // RULE16
            b_out[n] = pick(a_in, field_of(b_half, n));
            b_oe[n] = field_of(b_half, n)[tbx_pkg::OE_BIT]; // RULE16
        end
    end
endmodule
`default_nettype wire

// ==== design/tbx_trigger_crossbar.sv ====
// top: axi4-lite registers, shared-pin steering and trigger crossbar
`timescale 1ns/1ns
`default_nettype none
module tbx_trigger_crossbar #(
    parameter int unsigned PINS = 7
) (
    input wire logic sys_clk,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // board-side signals
    input wire logic external_convert_strobe_in,
    output logic external_convert_strobe_out,
    input wire logic frequency_output,
    input wire logic counter2_output,
    output logic counter1_gate_in,
    input wire logic counter5_source_in_ext,
    output logic counter5_source_in,
    input wire logic counter5_output,
    output logic acquisition_stop_trigger,
    input wire logic counter1_output,
    input wire logic acquisition_start_trigger_in,
    output logic acquisition_start_trigger_out,
    // shared trigger lines
    input wire logic [PINS-1:0] bus_trigger_line_in,
    output logic [PINS-1:0] bus_trigger_line_out,
    output logic [PINS-1:0] bus_trigger_line_oe
);
    // ****************************************
    // register state
    // ****************************************
    logic [55:0] pending_ff, nxt_pending;
    logic [55:0] active_ff, nxt_active;
    tbx_pkg::tbx_shared_ctrl_t ctrl_ff, nxt_ctrl;
    logic aw_got_ff, nxt_aw_got;
    logic w_got_ff, nxt_w_got;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [PINS-1:0] line_s1_ff, line_s2_ff;
    logic [PINS-1:0] aext_s1_ff, aext_s2_ff;

    logic do_write;
    logic do_read;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ****************************************
    // write path
    // ****************************************
    always_comb
    begin
        logic aw_ok;
        logic w_ok;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        aw_ok = aw_got_ff || (s_axi_awvalid && s_axi_awready);
        w_ok = w_got_ff || (s_axi_wvalid && s_axi_wready);
        addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
        data = w_got_ff ? wdata_ff : s_axi_wdata;
        strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
        nxt_aw_got = aw_ok;
        nxt_w_got = w_ok;
        nxt_awaddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_ff;
        nxt_wdata = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_ff;
        nxt_wstrb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_ff;
        nxt_pending = pending_ff;
        nxt_active = active_ff;
        nxt_ctrl = ctrl_ff;
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bresp = bresp_ff;
        do_write = aw_ok && w_ok;
        if (do_write)
        begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = tbx_pkg::RESP_OKAY;
            unique case (addr[7:2])
                tbx_pkg::SHIFT_IN_OFS[7:2]:
                begin
                    // new bit enters at the top so bit 0, sent first, ends at bit 0
                    if (strb[0])
                        nxt_pending = {data[0], pending_ff[55:1]}; // RULE10 RULE17
                end
                tbx_pkg::LOAD_STROBE_OFS[7:2]:
                begin
                    // only a byte-lane-0 write of zero loads; other values are ignored
                    if (strb[0] && data[7:0] == tbx_pkg::STROBE_LOAD_VALUE)
                        nxt_active = pending_ff; // RULE11
                end
                tbx_pkg::SHARED_CTRL_OFS[7:2]:
                begin
                    if (strb[0])
                        nxt_ctrl = tbx_pkg::tbx_shared_ctrl_t'(data[3:0]);
                end
                tbx_pkg::PENDING_LO_OFS[7:2], tbx_pkg::PENDING_HI_OFS[7:2],
                tbx_pkg::ACTIVE_LO_OFS[7:2], tbx_pkg::ACTIVE_HI_OFS[7:2]:
                begin
                    nxt_bresp = tbx_pkg::RESP_OKAY;
                end
                default:
                begin
                    nxt_bresp = tbx_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb
    begin
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        do_read = s_axi_arvalid && s_axi_arready;
        if (do_read)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = tbx_pkg::RESP_OKAY;
            unique case (s_axi_araddr[7:2])
                tbx_pkg::SHIFT_IN_OFS[7:2], tbx_pkg::LOAD_STROBE_OFS[7:2]:
                    nxt_rdata = 32'h0;
                tbx_pkg::SHARED_CTRL_OFS[7:2]:
                    nxt_rdata = {28'h0, ctrl_ff};
                tbx_pkg::PENDING_LO_OFS[7:2]:
                    nxt_rdata = pending_ff[31:0];
                tbx_pkg::PENDING_HI_OFS[7:2]:
                    nxt_rdata = {8'h0, pending_ff[55:32]};
                tbx_pkg::ACTIVE_LO_OFS[7:2]:
                    nxt_rdata = active_ff[31:0];
                tbx_pkg::ACTIVE_HI_OFS[7:2]:
                    nxt_rdata = {8'h0, active_ff[55:32]};
                default:
                begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = tbx_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pending_ff <= tbx_pkg::PATTERN_RESET;
            active_ff <= tbx_pkg::PATTERN_RESET; // RULE20
            ctrl_ff <= tbx_pkg::tbx_shared_ctrl_t'(tbx_pkg::SHARED_CTRL_RESET);
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= tbx_pkg::RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= tbx_pkg::RESP_OKAY;
            line_s1_ff <= '0;
            line_s2_ff <= '0;
            aext_s1_ff <= '0;
            aext_s2_ff <= '0;
        end
        else
        begin
            pending_ff <= nxt_pending;
            active_ff <= nxt_active;
            ctrl_ff <= nxt_ctrl;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            line_s1_ff <= bus_trigger_line_in;
            line_s2_ff <= line_s1_ff;
            aext_s1_ff <= {acquisition_start_trigger_in, counter1_output, 1'b0,
                           counter5_source_in_ext, 1'b0, frequency_output, external_convert_strobe_in};
            aext_s2_ff <= aext_s1_ff;
        end
    end

    // ****************************************
    // board-side pin levels and crossbar
    // ****************************************
    logic [PINS-1:0] a_level;
    logic [PINS-1:0] a_xbar_out;
    logic [PINS-1:0] a_xbar_oe;
    logic [PINS-1:0] xbar_b_out;
    logic [PINS-1:0] xbar_b_oe;
    logic pin2_level;
    logic pin4_level;

    // shared pins: level is whichever drivers are on; counters are local logic, no sync
    always_comb
    begin
        // RULE2 RULE3 RULE5
        pin2_level = (ctrl_ff.shared_pin2_drive_en && counter2_output)
                     || (a_xbar_oe[2] && a_xbar_out[2]);
        // RULE6 RULE8
        pin4_level = (ctrl_ff.shared_pin4_drive_en && counter5_output)
                     || (a_xbar_oe[4] && a_xbar_out[4]);
        a_level = aext_s2_ff;
        // pins driven by the crossbar see its own value, like a real driven wire
        for (int unsigned n = 0; n < PINS; n++)
        begin
            if (a_xbar_oe[n])
                a_level[n] = a_xbar_out[n];
        end
        a_level[2] = pin2_level;
        a_level[4] = pin4_level;
    end

    tbx_switch_core #(
        .PINS(PINS)
    ) u_core (
        .active_pattern(active_ff),
        .a_in(a_level),
        .b_in(line_s2_ff),
        .a_out(a_xbar_out),
        .a_oe(a_xbar_oe),
        .b_out(xbar_b_out),
        .b_oe(xbar_b_oe)
    ); // RULE1 RULE9

    // inputs fed only when their pin is driven; otherwise held low
    assign counter1_gate_in = ctrl_ff.shared_pin2_receive_en && pin2_level; // RULE4 RULE5
    assign acquisition_stop_trigger = ctrl_ff.shared_pin4_receive_en && pin4_level; // RULE7 RULE8
    assign external_convert_strobe_out = a_xbar_oe[0] && a_xbar_out[0]; // RULE16
    assign counter5_source_in = a_xbar_oe[3] && a_xbar_out[3]; // RULE16
    assign acquisition_start_trigger_out = a_xbar_oe[6] && a_xbar_out[6]; // RULE16
    assign bus_trigger_line_out = xbar_b_out & xbar_b_oe;
    assign bus_trigger_line_oe = xbar_b_oe; // RULE16 RULE1
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: register access, pattern loading and routing of the crossbar
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic sys_clk = 1'h0, rst, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, counter1_gate_in, counter5_source_in, acquisition_stop_trigger;
    logic external_convert_strobe_out, acquisition_start_trigger_out;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rs = 32'h20;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] ax = 7'h0, far_val = 7'h0, far_en = 7'h7F, bus_trigger_line_in, bus_trigger_line_out;
    logic [6:0] bus_trigger_line_oe;
    int failures = 0, samples_checked = 0;
    localparam logic [1:0] OK = tbx_pkg::RESP_OKAY;
    always #2 sys_clk = ~sys_clk;
    tbx_trigger_crossbar uut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_convert_strobe_in(ax[0]), .external_convert_strobe_out, .frequency_output(ax[1]),
        .counter2_output(ax[2]), .counter1_gate_in, .counter5_source_in_ext(ax[3]), .counter5_source_in,
        .counter5_output(ax[4]), .acquisition_stop_trigger, .counter1_output(ax[5]),
        .acquisition_start_trigger_in(ax[6]), .acquisition_start_trigger_out, .bus_trigger_line_in,
        .bus_trigger_line_out, .bus_trigger_line_oe);
    tbx_line_partner far_end (.sys_clk, .dev_out(bus_trigger_line_out), .dev_oe(bus_trigger_line_oe), .far_val,
        .far_en, .line(bus_trigger_line_in));
    // ********
    // helpers
    // ********
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        check(s_axi_bresp, er);
        s_axi_bready <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        check(s_axi_rdata, want);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'h0;
        @(posedge sys_clk);
    endtask
    // junk in the upper bits must not leak into the pattern
    task automatic load(input logic [55:0] p);
        for (int i = 0; i < 56; i++)
            wr(tbx_pkg::SHIFT_IN_OFS, (rnd() & 32'hFFFFFFFE) | {31'h0, p[i]}, OK);
    endtask
    // returns {b enables, b data, gate, stop, a0, a3, a6}
    function automatic logic [18:0] route(input logic [55:0] p, input logic [3:0] c, input logic [6:0] a,
        input logic [6:0] b);
        logic [6:0] av, al, bv, bo, be;
        logic [3:0] f;
        bv = a & {2'h3, c[2], 1'h1, c[0], 2'h3};
        for (int k = 0; k < 7; k++)
        begin
            f = p[28 + 4 * k +: 4];
            // select code 7 names no pin and yields a low level
            av[k] = f[0] & ((f[3:1] == 3'h7) ? 1'b0 : b[f[3:1]]);
            al[k] = f[0] ? av[k] | (bv[k] & (k == 2 || k == 4)) : bv[k];
        end
        for (int n = 0; n < 7; n++)
        begin
            f = p[4 * n +: 4];
            be[n] = f[0];
            bo[n] = f[0] & ((f[3:1] == 3'h7) ? 1'b0 : al[f[3:1]]);
        end
        return {be, bo, c[1] & al[2], c[3] & al[4], av[0], av[3], av[6]};
    endfunction
    // ********
    // main sequence
    // ********
    initial
    begin
        logic [55:0] p;
        logic [55:0] prev;
        logic [18:0] e;
        logic [3:0] c;
        rst = 1'h1;
        prev = 56'h0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (4) @(posedge sys_clk);
        check(bus_trigger_line_oe, 7'h0);
        rd(tbx_pkg::ACTIVE_LO_OFS, 32'h0, OK);
        rd(8'h1C, 32'h0, tbx_pkg::RESP_SLVERR);
        wr(8'h1C, 32'hFFFFFFFF, tbx_pkg::RESP_SLVERR);
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            // one side's enables off keeps the wire loop open
            p = i == 0 ? {28'h0000007, 28'h00B0000}
                : 56'({rnd(), rnd()}) & (i[0] ? 56'hEEEEEEEFFFFFFF : 56'hFFFFFFFEEEEEEE);
            wr(tbx_pkg::SHARED_CTRL_OFS, {28'h0, c}, OK);
            rd(tbx_pkg::SHARED_CTRL_OFS, {28'h0, c}, OK);
            load(p);
            wr(tbx_pkg::LOAD_STROBE_OFS, rnd() | 32'h1, OK);
            e = route(prev, c, 7'h0, 7'h0);
            check(bus_trigger_line_oe, e[18:12]);
            rd(tbx_pkg::PENDING_LO_OFS, p[31:0], OK);
            rd(tbx_pkg::PENDING_HI_OFS, {8'h0, p[55:32]}, OK);
            wr(tbx_pkg::LOAD_STROBE_OFS, rnd() & 32'hFFFFFF00, OK);
            rd(tbx_pkg::ACTIVE_HI_OFS, {8'h0, p[55:32]}, OK);
            e = route(p, c, 7'h0, 7'h0);
            far_en <= ~e[18:12];
            repeat (4)
            begin
                ax <= 7'(rnd());
                far_val <= 7'(rnd());
                repeat (4) @(posedge sys_clk);
                e = route(p, c, ax, far_val);
                check(bus_trigger_line_oe, e[18:12]);
                check(bus_trigger_line_out, e[11:5]);
                check({counter1_gate_in, acquisition_stop_trigger}, e[4:3]);
                check({external_convert_strobe_out, counter5_source_in, acquisition_start_trigger_out}, e[2:0]);
            end
            prev = p;
        end
        // reset in mid-run must drop every line enable again
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (2) @(posedge sys_clk);
        check(bus_trigger_line_oe, 7'h0);
        rd(tbx_pkg::ACTIVE_HI_OFS, 32'h0, OK);
        close_out();
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire

// ==== testbench/tbx_crossbar_properties.sv ====
// checker: bus timing, shared-pin steering and line enables of the crossbar
`timescale 1ns/1ns
`default_nettype none
module tbx_crossbar_chk #(
    parameter int unsigned PINS = 7
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic counter2_output,
    input wire logic counter1_gate_in,
    input wire logic counter5_output,
    input wire logic acquisition_stop_trigger,
    input wire logic [PINS-1:0] bus_trigger_line_out,
    input wire logic [PINS-1:0] bus_trigger_line_oe
);
    // ********
    // shadow of the shared control bits
    // ********
    logic [3:0] ctl_ff;
    logic [3:0] nxt_ctl;
    logic wr_both;
    assign wr_both = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    always_comb
    begin
        nxt_ctl = ctl_ff;
        if (wr_both && s_axi_awaddr == tbx_pkg::SHARED_CTRL_OFS && s_axi_wstrb[0])
            nxt_ctl = s_axi_wdata[3:0];
    end
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            ctl_ff <= 4'h0;
        else
            ctl_ff <= nxt_ctl;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence wr_taken;
        wr_both;
    endsequence
    // only the strobe may touch the active routing
    sequence plain_wr;
        wr_both && s_axi_awaddr != tbx_pkg::LOAD_STROBE_OFS;
    endsequence
    chk_oe_after_reset: assert property ($fell(rst) |-> (bus_trigger_line_oe == '0) [*4])
        else $error("line driven after reset");
    chk_out_gated: assert property ((bus_trigger_line_out & ~bus_trigger_line_oe) == '0)
        else $error("undriven line shows data");
    chk_route_frozen: assert property (plain_wr |=> $stable(bus_trigger_line_oe))
        else $error("routing changed without strobe");
    chk_bvalid_next: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write answer late");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_rvalid_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_gate_off: assert property (!ctl_ff[1] |-> !counter1_gate_in)
        else $error("gate taken from pin while off");
    chk_gate_follow: assert property (ctl_ff[1:0] == 2'h3 && counter2_output |-> counter1_gate_in)
        else $error("gate misses counter drive");
    chk_stop_off: assert property (!ctl_ff[3] |-> !acquisition_stop_trigger)
        else $error("stop taken from pin while off");
    chk_stop_follow: assert property (ctl_ff[3:2] == 2'h3 && counter5_output |-> acquisition_stop_trigger)
        else $error("stop misses counter drive");
endmodule
bind tbx_trigger_crossbar tbx_crossbar_chk #(.PINS(PINS)) chk_i (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .counter2_output, .counter1_gate_in, .counter5_output,
    .acquisition_stop_trigger, .bus_trigger_line_out, .bus_trigger_line_oe);
`default_nettype wire

// ==== testbench/tbx_line_partner.sv ====
// far-side model: other boards sharing the seven trigger lines
`timescale 1ns/1ns
`default_nettype none
module tbx_line_partner (
    input wire logic sys_clk,
    input wire logic [6:0] dev_out,
    input wire logic [6:0] dev_oe,
    input wire logic [6:0] far_val,
    input wire logic [6:0] far_en,
    output logic [6:0] line
);
    // a line nobody drives wanders instead of holding its last level
    logic [6:0] float_ff = 7'h55;
    always_ff @(posedge sys_clk)
        float_ff <= ~float_ff;
    // wired-or, so contention shows as a level rather than an unknown
    assign line = (dev_oe & dev_out) | (far_en & far_val) | (~dev_oe & ~far_en & float_ff);
endmodule
`default_nettype wire
